// ---- clock_control_pkg.sv ----
// Contract
// - Seven-bit prescaler on primary clock, three taps
// - Six-bit counter overflow: ready, reset release, wake
// - Preset prescaler and counter to 0078 hex
// - Selected clock feeds all modules except timebase
// - Select 00 /2, 01 /4, 10 /64, 11 secondary/2
// - Reset selects primary divided by two
// - Secondary clock never stops while powered
// - STOP or cleared enable stops primary clock
// - Primary source STOP: clear counter, wait overflow
// - Secondary source STOP: resume at once, ready later
// - Cleared enable presets; re-enable readies after 8072
// - Disabled primary stays off after STOP exit
// - STOP gates clocks, clears ready, clears counter
// - STOP exits on reset or listed wake sources
// - Primary source STOP holds CPU until overflow
// - Secondary source STOP resumes without recovery delay
// - WAIT halts CPU clock only, any interrupt ends
// - Start-up delay per reset kind and state
// - Ready cleared by power-on and enable clear
package clock_control_pkg;

    // ------------------------------------------------------------
    // Counter geometry
    // ------------------------------------------------------------
    localparam int          PRESC_W      = 7;
    localparam int          STAB_W       = 6;
    localparam logic [6:0]  PRESC_PRESET = 7'h78;
    localparam logic [5:0]  STAB_PRESET  = 6'h00;
    localparam logic [6:0]  PRESC_LAST   = 7'h7F;
    localparam logic [5:0]  STAB_LAST    = 6'h3F;
    localparam int          TAP_DIV2     = 0;
    localparam int          TAP_DIV4     = 1;
    localparam int          TAP_DIV64    = 5;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  OFS_CTRL     = 4'h0;
    localparam logic [3:0]  OFS_STATUS   = 4'h4;
    localparam logic [3:0]  OFS_COUNT    = 4'h8;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_SEL_LO  = 1;
    localparam logic        EN_RESET     = 1'b1;
    localparam logic [1:0]  SEL_RESET    = 2'h0;
    localparam int          ST_READY     = 0;
    localparam int          ST_POR_DONE  = 1;
    localparam int          ST_ACT_SEL   = 2;
    localparam int          ST_MODE      = 4;
    localparam int          ST_PRI_RUN   = 6;
    localparam int          CNT_STAB     = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_PRI_DIV2  = 2'b00,
        SEL_PRI_DIV4  = 2'b01,
        SEL_PRI_DIV64 = 2'b10,
        SEL_SEC_DIV2  = 2'b11
    } clk_sel_t;

    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_WAIT = 2'b01,
        MODE_STOP = 2'b10,
        MODE_HOLD = 2'b11
    } mode_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } avmm_rsp_t;

    typedef struct packed {
        logic        ext_irq;
        logic        keyboard_wakeup_interrupt;
        logic        spi_slave_activity;
        logic        timebase_interrupt;
        logic        any_interrupt;
    } wake_t;

endpackage

// ---- clock_control.sv ----
`timescale 1ns/1ps
module clock_control
    import clock_control_pkg::*;
(
    input  wire logic      ref_clk_in,
    input  wire logic      nrst_in,
    input  wire logic      primary_crystal_clock_in,
    input  wire logic      secondary_crystal_clock_in,
    input  wire avmm_req_t avmm_in,
    output avmm_rsp_t      avmm_out,
    input  wire logic      stop_exec_in,
    input  wire logic      wait_exec_in,
    input  wire logic      ext_reset_in,
    input  wire wake_t     wake_in,
    output logic           sys_clk_out,
    output logic           cpu_clk_out,
    output logic           periph_clk_out,
    output logic           timebase_clk_out,
    output logic           timebase_tick_out,
    output logic           primary_osc_enable_out,
    output logic           power_on_reset_out,
    output logic           cpu_hold_out,
    output logic           primary_clock_ready_flag_out
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic       rst_n;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  pri_sync;
        logic [2:0]  sec_sync;
        logic [6:0]  presc;
        logic [5:0]  stab;
        logic        sec_div;
        logic        ready;
        logic        por_done;
        mode_t       mode;
        logic        enable;
        clk_sel_t    sel;
        clk_sel_t    act_sel;
        logic        switching;
        logic        sys_clk;
        logic        cpu_gate;
        logic        periph_gate;
        logic        cpu_clk;
        logic        periph_clk;
        logic        tb_tick;
        logic        bus_ack;
        logic [31:0] rdata;
    } state_t;

    state_t st;
    state_t next_st;

    logic pri_edge;
    logic sec_edge;
    logic pri_run;
    logic tick128;
    logic ovf;
    logic tap;
    logic sel_ok;
    logic wake_stop;
    logic wr_ctrl;
    logic bus_req;

    always_comb begin
        next_st = st;

        // Pin synchronisers; stages two and three feed the edge detectors
        next_st.pri_sync = {st.pri_sync[1:0], primary_crystal_clock_in};
        next_st.sec_sync = {st.sec_sync[1:0], secondary_crystal_clock_in};
        pri_edge = st.pri_sync[1] & ~st.pri_sync[2];
        sec_edge = st.sec_sync[1] & ~st.sec_sync[2];

        // Secondary divider free-runs in every mode
        if (sec_edge) begin
            next_st.sec_div = ~st.sec_div;
        end

        // ------------------------------------------------------------
        // Bus slave, one wait state
        // ------------------------------------------------------------
        bus_req = avmm_in.read | avmm_in.write;
        next_st.bus_ack = bus_req & ~st.bus_ack;
        wr_ctrl = avmm_in.write & st.bus_ack & (avmm_in.address == OFS_CTRL);
        if (avmm_in.read & ~st.bus_ack) begin
            if (avmm_in.address == OFS_CTRL) begin
                next_st.rdata = {29'h0, st.sel, st.enable};
            end else if (avmm_in.address == OFS_STATUS) begin
                next_st.rdata = {25'h0, pri_run_f(st), st.mode, st.act_sel,
                                 st.por_done, st.ready};
            end else if (avmm_in.address == OFS_COUNT) begin
                next_st.rdata = {18'h0, st.stab, 1'b0, st.presc};
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end
        if (wr_ctrl) begin
            next_st.enable = avmm_in.writedata[CTRL_EN_BIT];
            next_st.sel    = clk_sel_t'(avmm_in.writedata[CTRL_SEL_LO +: 2]);
        end

        // ------------------------------------------------------------
        // Prescaler and stabilisation counter
        // ------------------------------------------------------------
        pri_run = pri_run_f(st);
        tick128 = pri_run & pri_edge & (st.presc == PRESC_LAST);
        ovf     = tick128 & (st.stab == STAB_LAST);
        next_st.tb_tick = tick128;
        if (pri_run & pri_edge) begin
            next_st.presc = st.presc + 7'h01;
        end
        if (tick128) begin
            next_st.stab = st.stab + 6'h01;
        end
        if (ovf) begin
            next_st.ready    = 1'b1;
            next_st.por_done = 1'b1;
        end

        // ------------------------------------------------------------
        // Low-power modes
        // ------------------------------------------------------------
        wake_stop = wake_in.ext_irq | wake_in.keyboard_wakeup_interrupt
                  | wake_in.spi_slave_activity | wake_in.timebase_interrupt;
        case (st.mode)
            MODE_RUN: begin
                if (stop_exec_in) begin
                    next_st.mode  = MODE_STOP;
                    next_st.stab  = STAB_PRESET;
                    next_st.ready = 1'b0;
                end else if (wait_exec_in) begin
                    next_st.mode = MODE_WAIT;
                end
            end
            MODE_WAIT: begin
                if (wake_in.any_interrupt | wake_stop) begin
                    next_st.mode = MODE_RUN;
                end
            end
            MODE_STOP: begin
                if (wake_stop) begin
                    if (st.act_sel == SEL_SEC_DIV2) begin
                        next_st.mode = MODE_RUN;
                    end else begin
                        next_st.mode = MODE_HOLD;
                    end
                end
            end
            MODE_HOLD: begin
                if (ovf) begin
                    next_st.mode = MODE_RUN;
                end
            end
            default: begin
                next_st.mode = MODE_RUN;
            end
        endcase

        // External reset: delay unless in RUN or WAIT with primary enabled
        if (ext_reset_in) begin
            next_st.sel    = SEL_PRI_DIV2;
            next_st.enable = 1'b1;
            if ((st.mode == MODE_RUN || st.mode == MODE_WAIT) && st.enable) begin
                next_st.mode = MODE_RUN;
            end else begin
                next_st.mode = MODE_HOLD;
            end
        end

        // Cleared enable presets both counters and drops ready
        if (!next_st.enable) begin
            next_st.presc = PRESC_PRESET;
            next_st.stab  = STAB_PRESET;
            next_st.ready = 1'b0;
        end

        // ------------------------------------------------------------
        // Source switching
        // ------------------------------------------------------------
        tap     = tap_f(st.act_sel, st.presc, st.sec_div);
        sel_ok  = (st.sel == SEL_SEC_DIV2) | st.ready;
        if (st.switching) begin
            if (!tap) begin
                next_st.switching = 1'b0;
            end
        end else if (st.sel != st.act_sel && sel_ok && !tap && !st.sys_clk) begin
            next_st.act_sel   = st.sel;
            next_st.switching = 1'b1;
        end
        next_st.sys_clk = tap & ~st.switching;

        // Gates change only while the clock is low
        if (!st.sys_clk) begin
            next_st.cpu_gate    = (st.mode == MODE_RUN);
            next_st.periph_gate = (st.mode == MODE_RUN)
                                | (st.mode == MODE_WAIT);
        end
        next_st.cpu_clk    = st.sys_clk & st.cpu_gate & st.por_done;
        next_st.periph_clk = st.sys_clk & st.periph_gate & st.por_done;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic pri_run_f(input state_t s);
        pri_run_f = s.enable & (s.mode != MODE_STOP);
    endfunction

    function automatic logic tap_f(input clk_sel_t s, input logic [6:0] p,
                                   input logic d);
        case (s)
            SEL_PRI_DIV2:  tap_f = p[TAP_DIV2];
            SEL_PRI_DIV4:  tap_f = p[TAP_DIV4];
            SEL_PRI_DIV64: tap_f = p[TAP_DIV64];
            default:       tap_f = d;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.presc    <= PRESC_PRESET;
            st.stab     <= STAB_PRESET;
            st.ready    <= 1'b0;
            st.por_done <= 1'b0;
            st.mode     <= MODE_HOLD;
            st.enable   <= EN_RESET;
            st.sel      <= clk_sel_t'(SEL_RESET);
            st.act_sel  <= clk_sel_t'(SEL_RESET);
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avmm_out.waitrequest      = (avmm_in.read | avmm_in.write) & ~st.bus_ack;
    assign avmm_out.readdata         = st.rdata;
    assign sys_clk_out               = st.sys_clk;
    assign cpu_clk_out               = st.cpu_clk;
    assign periph_clk_out            = st.periph_clk;
    assign timebase_clk_out          = st.sec_div;
    assign timebase_tick_out         = st.tb_tick;
    assign primary_osc_enable_out    = pri_run_f(st);
    assign power_on_reset_out        = ~st.por_done;
    assign cpu_hold_out              = (st.mode == MODE_HOLD) | (st.mode == MODE_STOP);
    assign primary_clock_ready_flag_out = st.ready;

endmodule

// ---- clock_control_assertions.sv ----
`timescale 1ns/1ps
module clock_control_assertions (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic sys_clk_out,
    input wire logic cpu_clk_out,
    input wire logic periph_clk_out,
    input wire logic timebase_clk_out,
    input wire logic timebase_tick_out,
    input wire logic primary_osc_enable_out,
    input wire logic power_on_reset_out,
    input wire logic primary_clock_ready_flag_out
);
    // ----------------------------------------
    // Start-up timing helpers
    // ----------------------------------------
    localparam int MIN_CYC = 20000;
    localparam int MAX_CYC = 20700;
    int run_cyc;
    int tb_idle;
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_cyc <= '0;
            tb_idle <= '0;
        end else begin
            run_cyc <= primary_osc_enable_out ? run_cyc + 1 : '0;
            tb_idle <= $changed(timebase_clk_out) ? '0 : tb_idle + 1;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    a_por_gates: assert property (
        power_on_reset_out |-> !cpu_clk_out && !periph_clk_out)
        else $error("clock runs in power-on reset");
    a_por_unready: assert property (
        power_on_reset_out |-> !primary_clock_ready_flag_out)
        else $error("ready set during power-on reset");
    a_off_unready: assert property (
        !primary_osc_enable_out |-> !primary_clock_ready_flag_out)
        else $error("ready set while primary is off");
    a_ready_early: assert property (
        $rose(primary_clock_ready_flag_out) |-> run_cyc >= MIN_CYC)
        else $error("ready set too early");
    a_ready_late: assert property (
        primary_osc_enable_out && !primary_clock_ready_flag_out |-> run_cyc < MAX_CYC)
        else $error("ready set too late");
    a_tick_single: assert property (
        $rose(timebase_tick_out) |=> !timebase_tick_out [*8])
        else $error("tick wider than one cycle");
    a_tb_alive: assert property (
        tb_idle < 32'hC)
        else $error("timebase clock stopped");
    a_sys_high: assert property (
        $rose(sys_clk_out) |=> sys_clk_out)
        else $error("runt high pulse on system clock");
    a_sys_low: assert property (
        $fell(sys_clk_out) |=> !sys_clk_out)
        else $error("runt low pulse on system clock");
endmodule

// ---- crystal_pair.sv ----
`timescale 1ns/1ps
module crystal_pair (
    input  wire logic enable_in,
    output logic      primary_out,
    output logic      secondary_out
);
    // ----------------------------------------
    // Crystal oscillators
    // ----------------------------------------
    initial begin
        secondary_out = 1'b0;
        #7;
        forever #350 secondary_out = ~secondary_out;
    end
    // Primary stands low while shut down
    initial begin
        primary_out = 1'b0;
        #13;
        forever #125 primary_out = enable_in ? ~primary_out : 1'b0;
    end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb
    import clock_control_pkg::*;
;
    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] value;
    } note_t;
    logic      ref_clk_in   = 1'b0;
    logic      nrst_in      = 1'b0;
    logic      stop_exec_in = 1'b0;
    logic      wait_exec_in = 1'b0;
    logic      ext_reset_in = 1'b0;
    avmm_req_t avmm_in      = '0;
    wake_t     wake_in      = '0;
    avmm_rsp_t avmm_out;
    logic      pri_clk, sec_clk, sys_clk, cpu_clk, periph_clk, hold, osc_en, por, ready;
    note_t     notes[$];
    int        per[4] = '{5, 10, 160, 14};
    int        fails = 0;
    int        n_compared = 0;
    int        cyc = 0;
    int        n = 0;
    crystal_pair i_crystal_pair (
        .enable_in(osc_en), .primary_out(pri_clk), .secondary_out(sec_clk));
    clock_control i_clock_control (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .primary_crystal_clock_in(pri_clk),
        .secondary_crystal_clock_in(sec_clk), .avmm_in(avmm_in), .avmm_out(avmm_out),
        .stop_exec_in(stop_exec_in), .wait_exec_in(wait_exec_in), .ext_reset_in(ext_reset_in),
        .wake_in(wake_in), .sys_clk_out(sys_clk), .cpu_clk_out(cpu_clk),
        .periph_clk_out(periph_clk), .timebase_clk_out(), .timebase_tick_out(),
        .primary_osc_enable_out(osc_en), .power_on_reset_out(por), .cpu_hold_out(hold),
        .primary_clock_ready_flag_out(ready));
    // ----------------------------------------
    // Clock, tasks and result monitor
    // ----------------------------------------
    always #50 ref_clk_in = ~ref_clk_in;
    always @(posedge pri_clk) n++;
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fails++;
            test_done();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    always @(posedge ref_clk_in) begin
        if (avmm_in.read && avmm_out.waitrequest === 1'b0 && notes.size() > 0) begin
            check(avmm_out.readdata & notes[0].mask, notes[0].value);
            void'(notes.pop_front());
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avmm_in <= '{read: !wr, write: wr, address: a, writedata: d};
        do @(posedge ref_clk_in); while (avmm_out.waitrequest !== 1'b0);
        avmm_in <= '0;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
        notes.push_back('{m, v});
        bus(1'b0, a, '0);
    endtask
    task automatic ready_after(input int lo, input int hi);
        wait (ready === 1'b1);
        check(32'(n >= lo && n <= hi), 32'h1);
        repeat (2) @(posedge ref_clk_in);
    endtask
    task automatic period(input int exp);
        longint t;
        repeat (3) @(posedge sys_clk);
        t = $time;
        @(posedge sys_clk);
        check(32'(($time - t) / 100), 32'(exp));
        @(posedge ref_clk_in);
    endtask
    task automatic stop_wake(input wake_t src);
        stop_exec_in <= 1'b1;
        @(posedge ref_clk_in);
        stop_exec_in <= 1'b0;
        @(posedge ref_clk_in);
        check(32'({hold, ready, osc_en}), 32'h4);
        repeat ($urandom_range(20, 2)) @(posedge ref_clk_in);
        wake_in <= src;
        @(posedge ref_clk_in);
        wake_in <= '0;
        repeat (3) @(posedge ref_clk_in);
    endtask
    task automatic clk_seen(input logic [1:0] exp);
        logic [1:0] seen;
        seen = '0;
        repeat (10) @(posedge ref_clk_in);
        repeat (30) begin
            @(posedge ref_clk_in);
            seen = seen | {cpu_clk, periph_clk};
        end
        check(32'(seen), 32'(exp));
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h7ED4C7A7));
        repeat (2) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        n = 0;
        repeat (3) @(posedge ref_clk_in);
        rd(OFS_CTRL, 32'h7, 32'h1);
        rd(OFS_STATUS, 32'hF, 32'h0);
        rd(4'hC, 32'hFFFFFFFF, 32'h0);
        check(32'(por), 32'h1);
        ready_after(8070, 8076);
        check(32'(por), 32'h0);
        $display("power-on test done");
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, OFS_CTRL, 32'(s * 2 + 1));
            period(per[s]);
            rd(OFS_STATUS, 32'hC, 32'(s * 4));
        end
        $display("select test done");
        bus(1'b1, OFS_CTRL, 32'h6);
        check(32'({osc_en, ready}), 32'h0);
        rd(OFS_COUNT, 32'h3F7F, 32'h78);
        bus(1'b1, OFS_STATUS, $urandom());
        rd(OFS_CTRL, 32'h7, 32'h6);
        for (int k = 0; k < 4; k++) begin
            stop_wake(wake_t'(5'h10 >> k));
            check(32'({hold, osc_en}), 32'h0);
        end
        n = 0;
        bus(1'b1, OFS_CTRL, 32'h7);
        ready_after(8070, 8076);
        $display("enable test done");
        n = 0;
        stop_wake(wake_t'(5'h10 >> $urandom_range(3, 0)));
        check(32'({hold, osc_en, ready}), 32'h2);
        ready_after(8062, 8194);
        wait_exec_in <= 1'b1;
        @(posedge ref_clk_in);
        wait_exec_in <= 1'b0;
        clk_seen(2'b01);
        rd(OFS_STATUS, 32'h30, 32'h10);
        wake_in <= wake_t'(5'h01);
        @(posedge ref_clk_in);
        wake_in <= '0;
        clk_seen(2'b11);
        $display("secondary stop and wait test done");
        bus(1'b1, OFS_CTRL, 32'h1);
        period(5);
        n = 0;
        stop_wake(wake_t'(5'h10 >> $urandom_range(3, 0)));
        check(32'(hold), 32'h1);
        ready_after(8062, 8194);
        check(32'(hold), 32'h0);
        bus(1'b1, OFS_CTRL, 32'h3);
        ext_reset_in <= 1'b1;
        @(posedge ref_clk_in);
        ext_reset_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        check(32'({hold, ready}), 32'h1);
        rd(OFS_CTRL, 32'h7, 32'h1);
        $display("primary stop and reset test done");
        test_done();
    end
endmodule
bind clock_control clock_control_assertions i_clock_control_assertions (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sys_clk_out(sys_clk_out),
    .cpu_clk_out(cpu_clk_out), .periph_clk_out(periph_clk_out),
    .timebase_clk_out(timebase_clk_out), .timebase_tick_out(timebase_tick_out),
    .primary_osc_enable_out(primary_osc_enable_out), .power_on_reset_out(power_on_reset_out),
    .primary_clock_ready_flag_out(primary_clock_ready_flag_out));
